// ---- logic/cefh_core.sv ----
// Core end: error outputs, internal error intake, function reset pending flags.
// Assumes the configuration decoder supplies reset starts and request targets
// on the same clock; the user end sits on the other side of cefh_if.
`timescale 1ns/10ps
`default_nettype none
module cefh_core (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Mode and masking
	input wire logic root_port_mode,
	input wire logic fatal_report_en,
	input wire logic nonfatal_report_en,
	input wire logic [3:0] pf_enabled,
	// Errors detected by the core, per function
	input wire logic [3:0] pf_fatal_detect,
	input wire logic [3:0] pf_nonfatal_detect,
	input wire logic remote_err_msg,
	// Uncorrectable internal error reporting
	input wire logic [3:0] aer_msg_en,
	output logic [3:0] uncor_internal_status,
	output logic uncor_msg_send,
	// Function reset starts from configuration space
	input wire logic [3:0] pf_reset_start,
	input wire logic [251:0] vf_reset_start,
	// Configuration request target
	input wire logic cfg_req_valid,
	input wire logic cfg_req_is_vf,
	input wire logic [7:0] cfg_req_func,
	output cefh_pkg::cefh_cpl_type cfg_req_answer,
	// User side
	cefh_if.core link
);
	// Error status and outputs
	logic [3:0] fatal_stat_ff;
	logic [3:0] nonfatal_stat_ff;
	logic [3:0] nxt_fatal_stat;
	logic [3:0] nxt_nonfatal_stat;
	logic ep_fatal_lvl;
	logic ep_nonfatal_lvl;
	logic ep_fatal_pulse;
	logic ep_nonfatal_pulse;
	logic rp_fatal_lvl;
	logic rp_nonfatal_lvl;
	logic nxt_fatal_out;
	logic nxt_nonfatal_out;
	logic fatal_out_ff;
	logic nonfatal_out_ff;
	// Internal error status and message
	logic [3:0] uncor_stat_ff;
	logic [3:0] nxt_uncor_stat;
	logic uncor_msg_allowed;
	logic nxt_msg;
	logic msg_ff;
	// Function reset pending flags
	logic [3:0] pf_pend_ff;
	logic [251:0] vf_pend_ff;
	logic [3:0] nxt_pf_pend;
	logic [251:0] nxt_vf_pend;
	logic [251:0] vf_done_mask;
	logic vf_done_hit;
	logic vf_index_ok;
	logic [7:0] vf_bit;
	// Configuration request lookup
	logic pf_req_hit;
	logic vf_req_hit;
	logic req_pending;

	// Unmasked local detects accumulate in each enabled function's status;
	// remote error messages never feed these, so they reach no output
	assign nxt_fatal_stat = fatal_stat_ff | (pf_fatal_detect & pf_enabled
		& {4{fatal_report_en}});
	assign nxt_nonfatal_stat = nonfatal_stat_ff | (pf_nonfatal_detect & pf_enabled
		& {4{nonfatal_report_en}});
	assign ep_fatal_lvl = |nxt_fatal_stat;
	assign ep_nonfatal_lvl = |nxt_nonfatal_stat;

	// Pulse shapers: the OR stays high while status is held, output pulses once
	cefh_err_pulse u_fatal_pulse (
		.clock(clock),
		.arst_n(arst_n),
		.level(ep_fatal_lvl),
		.pulse(ep_fatal_pulse)
	);
	cefh_err_pulse u_nonfatal_pulse (
		.clock(clock),
		.arst_n(arst_n),
		.level(ep_nonfatal_lvl),
		.pulse(ep_nonfatal_pulse)
	);

	// Root port follows each local unmasked detect, with no sticky status;
	// it reports every detect cycle, not just the first since reset
	assign rp_fatal_lvl = fatal_report_en & (|(pf_fatal_detect & pf_enabled));
	assign rp_nonfatal_lvl = nonfatal_report_en & (|(pf_nonfatal_detect & pf_enabled));
	// Mode picks the source ahead of the flops, so both modes share one output path
	assign nxt_fatal_out = root_port_mode ? rp_fatal_lvl : ep_fatal_pulse;
	assign nxt_nonfatal_out = root_port_mode ? rp_nonfatal_lvl : ep_nonfatal_pulse;

	// Sticky per-function status; only reset clears it, as no clear path exists
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fatal_stat_ff <= 4'h0;
			nonfatal_stat_ff <= 4'h0;
		end else begin
			fatal_stat_ff <= nxt_fatal_stat;
			nonfatal_stat_ff <= nxt_nonfatal_stat;
		end
	end

	// Error outputs leave from flops, one cycle after the detect
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fatal_out_ff <= 1'b0;
			nonfatal_out_ff <= 1'b0;
		end else begin
			fatal_out_ff <= nxt_fatal_out;
			nonfatal_out_ff <= nxt_nonfatal_out;
		end
	end
	assign link.err_fatal_out = fatal_out_ff;
	assign link.err_nonfatal_out = nonfatal_out_ff;

	// Internal error is not function-specific: all enabled functions flag it.
	// The single-cycle input shape is relied on; a held level keeps sending.
	assign nxt_uncor_stat = uncor_stat_ff | ({4{link.err_uncor_in}} & pf_enabled);
	// One message for the event if any enabled function allows sending
	assign uncor_msg_allowed = |(aer_msg_en & pf_enabled);
	assign nxt_msg = link.err_uncor_in & uncor_msg_allowed;

	// Internal error status and message flops
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			uncor_stat_ff <= 4'h0;
			msg_ff <= 1'b0;
		end else begin
			uncor_stat_ff <= nxt_uncor_stat;
			msg_ff <= nxt_msg;
		end
	end
	assign uncor_internal_status = uncor_stat_ff;
	assign uncor_msg_send = msg_ff;

	// Physical function pending: start sets, done clears; start wins a tie.
	// A done bit on a function that is not pending changes nothing.
	assign nxt_pf_pend = (pf_pend_ff & ~link.flr_done) | pf_reset_start;

	// Index 04h maps to bit 0; reserved indices clear nothing
	assign vf_index_ok = link.vf_reset_done_index >= cefh_pkg::VF_INDEX_BASE;
	assign vf_bit = link.vf_reset_done_index - cefh_pkg::VF_INDEX_BASE;
	// Gate on the range so a reserved index selects an all-zero mask
	assign vf_done_hit = link.vf_reset_done && vf_index_ok;
	assign vf_done_mask = vf_done_hit ? (252'h1 << vf_bit) : 252'h0;
	// Start wins a tie with done, so a fresh reset is never lost
	assign nxt_vf_pend = (vf_pend_ff & ~vf_done_mask) | vf_reset_start;

	// Physical pending flags are flops so the user sees a stable level
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pf_pend_ff <= cefh_pkg::PF_PENDING_RESET;
		end else begin
			pf_pend_ff <= nxt_pf_pend;
		end
	end
	assign link.flr_in_process = pf_pend_ff;

	// Virtual pending flags, kept apart as they form the wide bank
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			vf_pend_ff <= cefh_pkg::VF_PENDING_RESET;
		end else begin
			vf_pend_ff <= nxt_vf_pend;
		end
	end
	assign link.vf_reset_pending = vf_pend_ff;

	// Retry while the target's pending flag stands; cleared flag resumes service.
	// Out-of-range function numbers never match, so they are served normally.
	assign pf_req_hit = (cfg_req_func < 8'(cefh_pkg::PF_COUNT))
		&& pf_pend_ff[cfg_req_func[1:0]];
	assign vf_req_hit = (cfg_req_func < 8'(cefh_pkg::VF_COUNT))
		&& vf_pend_ff[cfg_req_func];
	assign req_pending = cfg_req_is_vf ? vf_req_hit : pf_req_hit;
	assign cfg_req_answer = (cfg_req_valid && req_pending)
		? cefh_pkg::CEFH_CPL_RETRY : cefh_pkg::CEFH_CPL_OK;

	// Remote messages are routed to the message interface elsewhere
	logic unused_remote;
	assign unused_remote = remote_err_msg;
endmodule
`default_nettype wire

// ---- logic/cefh_pkg.sv ----
// Package for the error report and function reset handshake block.
// Assumes one user clock domain shared by the core end and the user end.
package cefh_pkg;
	localparam int PF_COUNT = 4;
	localparam int VF_COUNT = 252;
	localparam int VF_INDEX_W = 8;
	localparam int PF_COUNT_W = 2;
	localparam logic [7:0] VF_INDEX_BASE = 8'h04;
	localparam logic [7:0] VF_INDEX_LAST = 8'hff;
	localparam logic [3:0] PF_PENDING_RESET = 4'h0;
	localparam logic [251:0] VF_PENDING_RESET = 252'h0;
	// Configuration request answer codes
	typedef enum logic [1:0] {
		CEFH_CPL_OK = 2'b00,
		CEFH_CPL_RETRY = 2'b01
	} cefh_cpl_type;
	// User end handshake states, Gray from idle to done; the return to idle flips both bits
	typedef enum logic [1:0] {
		CEFH_U_IDLE = 2'b00,
		CEFH_U_WORK = 2'b01,
		CEFH_U_DONE = 2'b11
	} cefh_ustate_type;
endpackage

// ---- logic/cefh_if.sv ----
// Sideband carrier between the core end and the user application end.
// Assumes both ends run on the same clock; no clocking block.
`timescale 1ns/10ps
`default_nettype none
interface cefh_if;
	logic err_fatal_out;
	logic err_nonfatal_out;
	logic err_uncor_in;
	logic [3:0] flr_done;
	logic [3:0] flr_in_process;
	logic vf_reset_done;
	logic [7:0] vf_reset_done_index;
	logic [251:0] vf_reset_pending;
	// Core end
	modport core (
		output err_fatal_out,
		output err_nonfatal_out,
		input err_uncor_in,
		input flr_done,
		output flr_in_process,
		input vf_reset_done,
		input vf_reset_done_index,
		output vf_reset_pending
	);
	// User application end
	modport user (
		input err_fatal_out,
		input err_nonfatal_out,
		output err_uncor_in,
		output flr_done,
		input flr_in_process,
		output vf_reset_done,
		output vf_reset_done_index,
		input vf_reset_pending
	);
endinterface
`default_nettype wire

// ---- logic/cefh_err_pulse.sv ----
// One-cycle pulse from a rising error level, used per error class.
// Assumes its input is formed on the same clock.
`timescale 1ns/10ps
`default_nettype none
module cefh_err_pulse (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Level in, pulse out
	input wire logic level,
	output logic pulse
);
	logic seen_ff;
	// Edge memory so a held status gives one pulse only
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			seen_ff <= 1'b0;
		end else begin
			seen_ff <= level;
		end
	end
	assign pulse = level & ~seen_ff;
endmodule
`default_nettype wire

// ---- logic/cefh_user.sv ----
// User application end: raises internal errors and completes function resets.
// Assumes the core end drives pending flags on the same clock.
`timescale 1ns/10ps
`default_nettype none
module cefh_user (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Application requests
	input wire logic uncor_event,
	input wire logic pf_work_done,
	input wire logic vf_work_done,
	// Status to the application
	output logic fatal_seen,
	output logic nonfatal_seen,
	output logic [7:0] vf_busy_index,
	output logic vf_busy,
	// Core side
	cefh_if.user link
);
	logic uncor_prev_ff;
	logic [3:0] pf_done_ff;
	logic vf_done_ff;
	logic [7:0] vf_index_ff;
	logic [7:0] vf_pick_ff;
	logic fatal_ff;
	logic nonfatal_ff;
	cefh_pkg::cefh_ustate_type vf_state_ff;
	cefh_pkg::cefh_ustate_type nxt_vf_state;
	logic [7:0] first_vf;
	logic any_vf;

	// Lowest pending virtual function, as a bit position
	always_comb begin
		first_vf = 8'h00;
		any_vf = 1'b0;
		for (int i = cefh_pkg::VF_COUNT - 1; i >= 0; i--) begin
			if (link.vf_reset_pending[i]) begin
				first_vf = 8'(i);
				any_vf = 1'b1;
			end
		end
	end

	// Errors from the core are caught as sticky levels for the application
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fatal_ff <= 1'b0;
			nonfatal_ff <= 1'b0;
			uncor_prev_ff <= 1'b0;
		end else begin
			fatal_ff <= fatal_ff | link.err_fatal_out;
			nonfatal_ff <= nonfatal_ff | link.err_nonfatal_out;
			uncor_prev_ff <= uncor_event;
		end
	end
	// Edge detect so a held request gives one single-cycle pulse
	assign link.err_uncor_in = uncor_event & ~uncor_prev_ff;

	// Physical done: one cycle per pending function when the application is done
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pf_done_ff <= 4'h0;
		end else begin
			pf_done_ff <= (pf_work_done ? link.flr_in_process : 4'h0) & ~pf_done_ff;
		end
	end
	assign link.flr_done = pf_done_ff;

	// Virtual function handshake, one function at a time
	always_comb begin
		nxt_vf_state = vf_state_ff;
		case (vf_state_ff)
			cefh_pkg::CEFH_U_IDLE: begin
				if (any_vf) begin
					nxt_vf_state = cefh_pkg::CEFH_U_WORK;
				end
			end
			cefh_pkg::CEFH_U_WORK: begin
				if (vf_work_done) begin
					nxt_vf_state = cefh_pkg::CEFH_U_DONE;
				end
			end
			default: begin
				nxt_vf_state = cefh_pkg::CEFH_U_IDLE;
			end
		endcase
	end

	// Done strobe and index come together from flops; index never reserved
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			vf_state_ff <= cefh_pkg::CEFH_U_IDLE;
			vf_pick_ff <= 8'h00;
			vf_done_ff <= 1'b0;
			vf_index_ff <= cefh_pkg::VF_INDEX_BASE;
		end else begin
			vf_state_ff <= nxt_vf_state;
			vf_done_ff <= (vf_state_ff == cefh_pkg::CEFH_U_WORK) && vf_work_done;
			if (vf_state_ff == cefh_pkg::CEFH_U_IDLE && any_vf) begin
				vf_pick_ff <= first_vf;
			end
			if (vf_state_ff == cefh_pkg::CEFH_U_WORK && vf_work_done) begin
				vf_index_ff <= vf_pick_ff + cefh_pkg::VF_INDEX_BASE;
			end
		end
	end
	assign link.vf_reset_done = vf_done_ff;
	assign link.vf_reset_done_index = vf_index_ff;
	assign fatal_seen = fatal_ff;
	assign nonfatal_seen = nonfatal_ff;
	assign vf_busy_index = vf_pick_ff;
	assign vf_busy = (vf_state_ff != cefh_pkg::CEFH_U_IDLE);
endmodule
`default_nettype wire

// ---- bench/cefh_checker.sv ----
// Checker: pulse and handshake rules on the sideband carrier.
// Assumes one clock; sits beside the carrier in the bench top.
`timescale 1ns/10ps
`default_nettype none
module cefh_checker (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Carrier signals
	input wire logic err_fatal_out,
	input wire logic err_nonfatal_out,
	input wire logic err_uncor_in,
	input wire logic [3:0] flr_done,
	input wire logic [3:0] flr_in_process,
	input wire logic vf_reset_done,
	input wire logic [7:0] vf_reset_done_index,
	input wire logic [251:0] vf_reset_pending
);
	default clocking dc @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Bit a done strobe frees; reserved indices free nothing
	wire logic [251:0] done_mask = (vf_reset_done && vf_reset_done_index >= 8'h04) ?
		(252'h1 << (vf_reset_done_index - 8'h04)) : 252'h0;
	// Done step, then the freed bits are low
	sequence pf_done_s; |flr_done; endsequence
	sequence pf_free_s; (flr_in_process & $past(flr_done)) == 4'h0; endsequence
	sequence vf_free_s; (vf_reset_pending & $past(done_mask)) == 252'h0; endsequence
	uncor_pulse_a: assert property (err_uncor_in |=> !err_uncor_in)
		else $error("uncorrectable input longer than one cycle");
	pf_hold_a: assert property (1 |=>
		($past(flr_in_process) & ~$past(flr_done) & ~flr_in_process) == 4'h0)
		else $error("pf pending dropped without done");
	pf_served_a: assert property ((flr_done & ~flr_in_process) == 4'h0)
		else $error("pf done on a function not pending");
	pf_clear_a: assert property (pf_done_s |=> pf_free_s)
		else $error("pf pending kept after done");
	vf_hold_a: assert property (1 |=>
		($past(vf_reset_pending) & ~$past(done_mask) & ~vf_reset_pending) == 252'h0)
		else $error("vf pending dropped without done");
	vf_clear_a: assert property (vf_reset_done |=> vf_free_s)
		else $error("vf pending kept after done");
	vf_index_a: assert property (vf_reset_done |-> vf_reset_done_index >= 8'h04)
		else $error("reserved vf index used");
	vf_served_a: assert property (vf_reset_done |-> (vf_reset_pending & done_mask) != 252'h0)
		else $error("vf index does not select a pending bit");
	vf_strobe_a: assert property (vf_reset_done |=> !vf_reset_done)
		else $error("vf done strobe longer than one cycle");
endmodule
`default_nettype wire

// ---- bench/cfg_error_and_flr_handshake_tb.sv ----
// Bench: core end and user end joined by the carrier, checker beside it.
// Assumes the package and the design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module cfg_error_and_flr_handshake_tb;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic rp, fen, nen, remote, cq_valid, cq_vf, uev, pwd, vwd, msg, fseen, nseen, busy;
	logic [3:0] pf_en, pf_fat, pf_nf, aer_en, pf_go, ustat;
	logic [251:0] vf_go;
	logic [7:0] cq_func, busy_idx;
	logic [15:0] lfsr = 16'h0063;
	logic [2:0] note_q[$];
	cefh_pkg::cefh_cpl_type ans;
	int err_count = 0;
	int checks_done = 0;
	int b;
	logic [7:0] want_idx;
	cefh_if link();
	wire logic [2:0] evt = {link.err_fatal_out, link.err_nonfatal_out, msg};
	// Both ends face each other across the carrier
	cefh_core cefh_core_inst (.clock(clock), .arst_n(arst_n), .root_port_mode(rp),
		.fatal_report_en(fen), .nonfatal_report_en(nen), .pf_enabled(pf_en),
		.pf_fatal_detect(pf_fat), .pf_nonfatal_detect(pf_nf), .remote_err_msg(remote),
		.aer_msg_en(aer_en), .uncor_internal_status(ustat), .uncor_msg_send(msg),
		.pf_reset_start(pf_go), .vf_reset_start(vf_go), .cfg_req_valid(cq_valid),
		.cfg_req_is_vf(cq_vf), .cfg_req_func(cq_func), .cfg_req_answer(ans), .link(link));
	cefh_user cefh_user_inst (.clock(clock), .arst_n(arst_n), .uncor_event(uev),
		.pf_work_done(pwd), .vf_work_done(vwd), .fatal_seen(fseen), .nonfatal_seen(nseen),
		.vf_busy_index(busy_idx), .vf_busy(busy), .link(link));
	cefh_checker cefh_checker_inst (.clock(clock), .arst_n(arst_n),
		.err_fatal_out(link.err_fatal_out), .err_nonfatal_out(link.err_nonfatal_out),
		.err_uncor_in(link.err_uncor_in), .flr_done(link.flr_done),
		.flr_in_process(link.flr_in_process), .vf_reset_done(link.vf_reset_done),
		.vf_reset_done_index(link.vf_reset_done_index), .vf_reset_pending(link.vf_reset_pending));
	initial begin
		forever #2 clock = ~clock;
	end
	// Random source, seeded at 99
	function automatic logic [15:0] step(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic tick;
		@(negedge clock);
	endtask
	task automatic check_lvl(input string what, input logic [251:0] exp, input logic [251:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_evt(input logic [2:0] exp, input logic [2:0] got);
		check_lvl("error pulses", {249'h0, exp}, {249'h0, got});
	endtask
	// Detect pulses held for n cycles
	task automatic pulse(input logic [3:0] f, input logic [3:0] nf, input int n);
		pf_fat = f;
		pf_nf = nf;
		repeat (n) tick;
		pf_fat = 4'h0;
		pf_nf = 4'h0;
		repeat (2) tick;
	endtask
	task automatic close_out;
		err_count += note_q.size();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Monitor: every pulse seen takes the oldest note; a pulse with no note is a fault
	always @(negedge clock) begin
		if (arst_n && evt !== 3'h0) begin
			if (note_q.size() == 0) check_evt(3'h0, evt);
			else check_evt(note_q.pop_front(), evt);
		end
	end
	// Watchdog well past the expected run length
	initial begin
		#(4 * 5000);
		err_count++;
		close_out();
	end
	initial begin
		{rp, remote, cq_valid, cq_vf, uev, pwd, vwd} = 7'h00;
		{fen, nen, pf_en, pf_fat, pf_nf, aer_en, pf_go} = {2'h3, 4'hf, 8'h00, 4'h1, 4'h0};
		vf_go = 252'h0;
		cq_func = 8'h00;
		repeat (10) tick;
		arst_n = 1'b1;
		tick;
		check_lvl("seen after reset", 252'h0, {fseen, nseen});
		// Endpoint: OR over functions, one pulse, later errors add none
		note_q.push_back(3'h6);
		pulse(4'h6, 4'h4, 1);
		check_lvl("seen sticky", 252'h3, {fseen, nseen});
		pulse(4'h1, 4'h1, 1);
		// Root port: remote, masked and disabled errors stay silent
		rp = 1'b1;
		remote = 1'b1;
		tick;
		remote = 1'b0;
		{fen, nen} = 2'h0;
		pulse(4'h2, 4'h2, 1);
		{fen, nen, pf_en} = {2'h3, 4'h1};
		pulse(4'h2, 4'h2, 1);
		pf_en = 4'hf;
		note_q.push_back(3'h4);
		note_q.push_back(3'h4);
		pulse(4'h8, 4'h0, 2);
		note_q.push_back(3'h2);
		pulse(4'h0, 4'h1, 1);
		// Internal error with and without message sending
		note_q.push_back(3'h1);
		uev = 1'b1;
		repeat (2) tick;
		check_lvl("uncor status", 252'hf, ustat);
		{uev, aer_en} = {1'b0, 4'h0};
		tick;
		uev = 1'b1;
		repeat (3) tick;
		// Each physical function: pending, retry, hold, release
		cq_valid = 1'b1;
		for (int i = 0; i < 4; i++) begin
			pf_go = 4'h1 << i;
			cq_func = 8'(i);
			tick;
			pf_go = 4'h0;
			check_lvl("pf pending", 252'h1 << i, link.flr_in_process);
			check_lvl("pf answer", cefh_pkg::CEFH_CPL_RETRY, ans);
			repeat (3) tick;
			check_lvl("pf held", 252'h1 << i, link.flr_in_process);
			pwd = 1'b1;
			for (int k = 0; k < 20 && link.flr_in_process !== 4'h0; k++) tick;
			pwd = 1'b0;
			check_lvl("pf answer", cefh_pkg::CEFH_CPL_OK, ans);
		end
		// Virtual functions: both end bits, random ones, then two at once
		cq_vf = 1'b1;
		for (int n = 0; n < 7; n++) begin
			lfsr = step(lfsr);
			b = (n == 0 || n == 6) ? 0 : (n == 1) ? 251 : int'(lfsr) % 252;
			vf_go = (n == 6) ? (252'h1 | (252'h1 << 251)) : (252'h1 << b);
			cq_func = 8'(b);
			tick;
			vf_go = 252'h0;
			if (n < 6) check_lvl("vf pending", 252'h1 << b, link.vf_reset_pending);
			check_lvl("vf answer", cefh_pkg::CEFH_CPL_RETRY, ans);
			tick;
			check_lvl("vf busy", {1'b1, 8'(b)}, {busy, busy_idx});
			vwd = 1'b1;
			for (int k = 0; k < 40 && link.vf_reset_pending !== 252'h0; k++) tick;
			vwd = 1'b0;
			check_lvl("vf answer", cefh_pkg::CEFH_CPL_OK, ans);
			want_idx = (n == 6) ? cefh_pkg::VF_INDEX_LAST : 8'(b) + cefh_pkg::VF_INDEX_BASE;
			check_lvl("vf index", want_idx, link.vf_reset_done_index);
		end
		// Mid-run reset: sticky state clears and endpoint reporting starts over
		{rp, uev} = 2'h0;
		arst_n = 1'b0;
		repeat (2) tick;
		check_lvl("reset index", cefh_pkg::VF_INDEX_BASE, link.vf_reset_done_index);
		check_lvl("reset status", 252'h0, {ustat, fseen, nseen});
		arst_n = 1'b1;
		tick;
		note_q.push_back(3'h4);
		pulse(4'h1, 4'h0, 1);
		close_out();
	end
endmodule
`default_nettype wire
